/* sbmsc_ctrl.sv */
// top of the sram burst, mode pin and sleep control block
// assumes the bus pins are driven by a controller on core_clk; mode and sleep pins are not
`timescale 1ns/1ps
`default_nettype none
module sbmsc_ctrl
    import sbmsc_pkg::*;
#(
    parameter int ADDR_W = 18,
    parameter int NUM_BYTES = 4,
    parameter int BYTE_W = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // synchronous command bus
    input wire logic clk_edge_gate,
    input wire logic chip_en1_n,
    input wire logic chip_en2,
    input wire logic chip_en3_n,
    input wire logic write_n,
    input wire logic [NUM_BYTES-1:0] byte_wr_n,
    input wire logic advance_load_select,
    input wire logic [ADDR_W-1:0] addr,
    // data pins, split into input, output and enable
    input wire logic [NUM_BYTES*BYTE_W-1:0] dq_in,
    output logic [NUM_BYTES*BYTE_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [NUM_BYTES-1:0] parity_data_lines_in,
    output logic [NUM_BYTES-1:0] parity_data_lines_out,
    output logic parity_data_lines_oe,
    // static mode pins, each but burst_order_select with a flag telling it is left open
    input wire logic burst_order_select,
    input wire logic flow_through_select,
    input wire logic flow_through_select_open,
    input wire logic deselect_cycle_select,
    input wire logic deselect_cycle_select_open,
    input wire logic drive_select,
    input wire logic drive_select_open,
    input wire logic parity_byte_enable,
    input wire logic parity_byte_enable_open,
    input wire logic sleep_request,
    input wire logic sleep_request_open,
    // memory core side
    output logic [ADDR_W-1:0] core_addr,
    output logic core_rd_en,
    input wire logic [NUM_BYTES*BYTE_W-1:0] core_rd_data,
    input wire logic [NUM_BYTES-1:0] core_rd_par,
    output logic core_wr_en,
    output logic [ADDR_W-1:0] core_wr_addr,
    output logic [NUM_BYTES-1:0] core_byte_en,
    output logic [NUM_BYTES*BYTE_W-1:0] core_wr_data,
    output logic [NUM_BYTES-1:0] core_wr_par,
    // mode and power status
    output logic pipelined_mode,
    output logic single_deselect,
    output logic high_drive,
    output logic sleep_active,
    output logic recovering
);

    localparam int DATA_W = NUM_BYTES * BYTE_W;

    // the counter only owns two address bits, so elaboration stops on a narrower bus
    if (ADDR_W < 3 || NUM_BYTES < 1 || BYTE_W < 1) begin : g_bad_params
        $error("sbmsc_ctrl: ADDR_W must be at least 3, byte counts at least 1");
    end

    // mode pins resolved against their pull devices, then synchronised
    logic [MODE_W-1:0] mode_raw;
    logic [MODE_W-1:0] mode_meta_reg; // read only by mode_sync_reg
    logic [MODE_W-1:0] mode_sync_reg;

    assign mode_raw[MODE_FLOW] = flow_through_select_open ? FLOW_OPEN_VAL : flow_through_select;
    assign mode_raw[MODE_DESEL] = deselect_cycle_select_open ? DESEL_OPEN_VAL : deselect_cycle_select;
    assign mode_raw[MODE_DRV] = drive_select_open ? DRV_OPEN_VAL : drive_select;
    assign mode_raw[MODE_PAR] = parity_byte_enable_open ? PAR_OPEN_VAL : parity_byte_enable;
    assign mode_raw[MODE_ORD] = burst_order_select;
    assign mode_raw[MODE_SLP] = sleep_request_open ? SLEEP_OPEN_VAL : sleep_request;

    // two flip-flops because the mode and sleep pins are not timed to core_clk
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode_meta_reg <= MODE_RST;
            mode_sync_reg <= MODE_RST;
        end else begin
            mode_meta_reg <= mode_raw;
            mode_sync_reg <= mode_meta_reg;
        end
    end

    // decoded modes
    logic pipe_on, dual_desel, par_on, interleave, sleep_sync;

    assign pipe_on = mode_sync_reg[MODE_FLOW];
    assign dual_desel = !mode_sync_reg[MODE_DESEL];
    assign par_on = !mode_sync_reg[MODE_PAR];
    assign interleave = mode_sync_reg[MODE_ORD];
    assign sleep_sync = mode_sync_reg[MODE_SLP]; // high two edges after the pin
    assign pipelined_mode = pipe_on;
    assign single_deselect = !dual_desel;
    assign high_drive = !mode_sync_reg[MODE_DRV];

    // sleep sequencer
    sbmsc_sleep_e slp_state_reg;
    sbmsc_sleep_e slp_state_next;
    logic [7:0] rec_cnt_reg; // cycles spent recovering
    logic [7:0] rec_cnt_next;
    logic in_sleep, rec_done;

    assign in_sleep = sleep_sync || (slp_state_reg == SLP_ASLEEP);
    assign rec_done = (rec_cnt_reg == 8'(SLEEP_RECOVERY_CYC - 1));
    assign sleep_active = in_sleep;
    assign recovering = (slp_state_reg == SLP_RECOVER);

    // next sleep state; a new request during recovery goes straight back
    always_comb begin
        slp_state_next = slp_state_reg;
        rec_cnt_next = rec_cnt_reg;
        case (slp_state_reg)
            SLP_AWAKE: begin
                slp_state_next = sleep_sync ? SLP_ASLEEP : SLP_AWAKE;
            end
            SLP_ASLEEP: begin
                rec_cnt_next = RECOVERY_CNT_RST;
                slp_state_next = sleep_sync ? SLP_ASLEEP : SLP_RECOVER;
            end
            SLP_RECOVER: begin
                rec_cnt_next = rec_cnt_reg + 8'h01;
                if (sleep_sync) begin
                    slp_state_next = SLP_ASLEEP;
                end else if (rec_done) begin
                    slp_state_next = SLP_AWAKE;
                end
            end
            default: begin
                slp_state_next = SLP_AWAKE;
            end
        endcase
    end

    // sleep state registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            slp_state_reg <= SLP_AWAKE;
            rec_cnt_reg <= RECOVERY_CNT_RST;
        end else begin
            slp_state_reg <= slp_state_next;
            rec_cnt_reg <= rec_cnt_next;
        end
    end

    // command decode
    logic freeze, selected, do_load, do_cont;
    logic burst_live_reg; // a read or write burst is open
    sbmsc_op_e burst_op_reg; // kind of the open burst
    sbmsc_op_e op_now;
    logic [ADDR_W-1:0] upper_reg; // high address bits of the burst
    logic [1:0] lsb_next;
    logic [ADDR_W-1:0] addr_next;

    // a held edge or sleep freezes the command, burst and data pipeline; nothing pending is lost
    assign freeze = clk_edge_gate || in_sleep;
    assign selected = !chip_en1_n && chip_en2 && !chip_en3_n;
    assign do_load = !advance_load_select && selected;
    assign do_cont = advance_load_select && burst_live_reg;

    // write loads met while recovering are refused as deselects; continues of an open write burst still write
    always_comb begin
        op_now = OP_DESEL;
        if (do_load) begin
            if (write_n) begin
                op_now = OP_READ;
            end else if (!recovering) begin
                op_now = OP_WRITE;
            end
        end else if (do_cont) begin
            op_now = burst_op_reg; // write abort still counts as a write
        end
    end

    sbmsc_burst_ctr u_burst_ctr (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .hold(freeze),
        .load(do_load),
        .advance(do_cont),
        .interleave(interleave),
        .load_lsb(addr[1:0]),
        .next_lsb(lsb_next)
    );

    // high bits come from the pins only on a load
    assign addr_next = do_load ? {addr[ADDR_W-1:2], lsb_next} : {upper_reg[ADDR_W-1:2], lsb_next};

    // first pipeline stage: command and address registered
    sbmsc_op_e s1_op_reg, s2_op_reg;
    logic [NUM_BYTES-1:0] s1_be_reg, s2_be_reg;
    logic [ADDR_W-1:0] s2_addr_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            burst_live_reg <= 1'b0;
            burst_op_reg <= OP_DESEL;
            upper_reg <= '0;
            core_addr <= '0;
            s1_op_reg <= OP_DESEL;
            s1_be_reg <= '0;
            s2_op_reg <= OP_DESEL;
            s2_be_reg <= '0;
            s2_addr_reg <= '0;
        end else if (!freeze) begin
            if (!advance_load_select) begin
                burst_live_reg <= (op_now != OP_DESEL);
                burst_op_reg <= op_now;
            end
            if (do_load || do_cont) begin
                upper_reg <= addr_next;
                core_addr <= addr_next;
            end
            s1_op_reg <= op_now;
            s1_be_reg <= ~byte_wr_n;
            s2_op_reg <= s1_op_reg;
            s2_be_reg <= s1_be_reg;
            s2_addr_reg <= core_addr;
        end
    end

    // the core reads the registered address in the cycle after the command
    assign core_rd_en = (s1_op_reg == OP_READ) && !in_sleep;

    // late write: data taken one edge after the command in flow-through, two in pipelined
    logic wr_due;
    logic [NUM_BYTES-1:0] wr_be;
    logic [ADDR_W-1:0] wr_addr;

    assign wr_due = pipe_on ? (s2_op_reg == OP_WRITE) : (s1_op_reg == OP_WRITE);
    assign wr_be = pipe_on ? s2_be_reg : s1_be_reg;
    assign wr_addr = pipe_on ? s2_addr_reg : core_addr;

    // a write with no byte enabled is an abort and touches nothing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            core_wr_en <= 1'b0;
            core_wr_addr <= '0;
            core_byte_en <= '0;
            core_wr_data <= '0;
            core_wr_par <= '0;
        end else begin
            core_wr_en <= wr_due && (|wr_be) && !freeze;
            if (wr_due && !freeze) begin
                core_wr_addr <= wr_addr;
                core_byte_en <= wr_be;
                core_wr_data <= dq_in;
                core_wr_par <= par_on ? parity_data_lines_in : '0;
            end
        end
    end

    // read data: stage a for flow-through, stage b adds the output register
    logic [DATA_W-1:0] rd_a_reg, rd_b_reg;
    logic [NUM_BYTES-1:0] pa_a_reg, pa_b_reg;
    logic va_reg, vb_reg;
    logic oe_ext_reg; // extra driven cycle for dual deselect
    logic out_valid;

    assign out_valid = pipe_on ? vb_reg : va_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_a_reg <= '0;
            rd_b_reg <= '0;
            pa_a_reg <= '0;
            pa_b_reg <= '0;
            va_reg <= 1'b0;
            vb_reg <= 1'b0;
            oe_ext_reg <= 1'b0;
        end else if (!freeze) begin // held read keeps the bus driven
            va_reg <= (s1_op_reg == OP_READ);
            vb_reg <= va_reg;
            if (s1_op_reg == OP_READ) begin
                rd_a_reg <= core_rd_data;
                pa_a_reg <= core_rd_par;
            end
            rd_b_reg <= rd_a_reg;
            pa_b_reg <= pa_a_reg;
            oe_ext_reg <= dual_desel && out_valid;
        end
    end

    // outputs fall to high impedance at once in sleep
    assign dq_out = pipe_on ? rd_b_reg : rd_a_reg;
    assign parity_data_lines_out = pipe_on ? pa_b_reg : pa_a_reg;
    assign dq_oe = (out_valid || (oe_ext_reg && !wr_due)) && !in_sleep;
    assign parity_data_lines_oe = dq_oe && par_on;

    // checks
    a_sleep_outputs: assert property (@(posedge core_clk) disable iff (sys_rst)
        in_sleep |-> !dq_oe && !parity_data_lines_oe && !core_wr_en)
        else $error("outputs active while asleep");
    a_sleep_entry: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sleep_request && !sleep_request_open)[*2] |=> sleep_active)
        else $error("sleep not entered two cycles after request");
    a_sleep_keeps_state: assert property (@(posedge core_clk) disable iff (sys_rst)
        sleep_active |=> $stable(core_addr) && $stable(burst_live_reg))
        else $error("state changed during sleep");
    a_recover_bound: assert property (@(posedge core_clk) disable iff (sys_rst)
        recovering && !sleep_sync |-> ##[1:16] !recovering)
        else $error("recovery did not end");
    a_recover_count: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(recovering) && !in_sleep |-> $past(rec_cnt_reg) == 8'(SLEEP_RECOVERY_CYC - 1))
        else $error("recovery length wrong");
    a_burst_steps: assert property (@(posedge core_clk) disable iff (sys_rst)
        do_cont && !freeze |=> core_addr[1:0] != $past(core_addr[1:0]))
        else $error("continue cycle did not step the address");
    a_upper_held: assert property (@(posedge core_clk) disable iff (sys_rst)
        do_cont && !freeze |=> core_addr[ADDR_W-1:2] == $past(core_addr[ADDR_W-1:2]))
        else $error("upper address moved inside a burst");
    a_load_address: assert property (@(posedge core_clk) disable iff (sys_rst)
        do_load && !freeze |=> core_addr == $past(addr))
        else $error("loaded address not taken");
    a_gate_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_edge_gate |=> $stable(s1_op_reg) && $stable(core_addr) && !core_wr_en)
        else $error("gated edge changed state");
    a_pipe_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        pipe_on && do_load && !write_n && !recovering && (|(~byte_wr_n)) && !freeze
        ##1 (!freeze && pipe_on)[*2] |=> core_wr_en)
        else $error("pipelined write not issued at third edge");
    a_parity_off: assert property (@(posedge core_clk) disable iff (sys_rst)
        !par_on |-> !parity_data_lines_oe && core_wr_par == '0)
        else $error("parity lines active while disabled");
    a_wrap_four: assert property (@(posedge core_clk) disable iff (sys_rst)
        (do_load && !freeze) ##1 (do_cont && !freeze)[*4] |=> core_addr[1:0] == $past(core_addr[1:0], 4))
        else $error("burst did not wrap after four");

    c_full_burst: cover property (@(posedge core_clk) disable iff (sys_rst)
        do_load ##1 do_cont[*3]);
    c_sleep_cycle: cover property (@(posedge core_clk) disable iff (sys_rst)
        sleep_active ##1 !sleep_active ##[1:16] !recovering);
    c_flow_write: cover property (@(posedge core_clk) disable iff (sys_rst)
        !pipe_on && core_wr_en);
    c_dual_desel: cover property (@(posedge core_clk) disable iff (sys_rst)
        dq_oe && !out_valid);

endmodule
`default_nettype wire

/* sbmsc_pkg.sv */
// shared constants and types for the sram burst, mode pin and sleep control block
// assumes a single 40 MHz core clock; no other file defines these names
package sbmsc_pkg;

    // clock and sleep timing, times in ns
    localparam int CLK_PERIOD_NS = 25;
    localparam int SLEEP_RECOVERY_NS = 100; // recovery time, plain default
    localparam int SLEEP_RECOVERY_RAW = (SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_RECOVERY_CYC = (SLEEP_RECOVERY_RAW < 1) ? 1 : SLEEP_RECOVERY_RAW;
    localparam int SLEEP_ENTRY_CYC = 2; // edges from request to sleep

    // burst counter values
    localparam logic [1:0] BURST_START = 2'h0;
    localparam logic [1:0] BURST_STEP = 2'h1;

    // values taken by mode pins that are left open (pull devices)
    localparam logic FLOW_OPEN_VAL = 1'b1;
    localparam logic DESEL_OPEN_VAL = 1'b1;
    localparam logic DRV_OPEN_VAL = 1'b1;
    localparam logic PAR_OPEN_VAL = 1'b0;
    localparam logic SLEEP_OPEN_VAL = 1'b0;

    // bit positions in the synchronised mode vector
    localparam int MODE_FLOW = 0;
    localparam int MODE_DESEL = 1;
    localparam int MODE_DRV = 2;
    localparam int MODE_PAR = 3;
    localparam int MODE_ORD = 4;
    localparam int MODE_SLP = 5;
    localparam int MODE_W = 6;

    // values after reset
    localparam logic [MODE_W-1:0] MODE_RST = 6'h07;
    localparam logic [7:0] RECOVERY_CNT_RST = 8'h00;

    // command decoded from the bus in one cycle
    typedef enum logic [1:0] {OP_DESEL, OP_READ, OP_WRITE} sbmsc_op_e;

    // sleep sequencing
    typedef enum logic [1:0] {SLP_AWAKE, SLP_ASLEEP, SLP_RECOVER} sbmsc_sleep_e;

endpackage

/* sbmsc_burst_ctr.sv */
// two-bit burst address generator with linear and interleaved order
// assumes load and advance are never high together and hold freezes every edge
`timescale 1ns/1ps
`default_nettype none
module sbmsc_burst_ctr
    import sbmsc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // control
    input wire logic hold,
    input wire logic load,
    input wire logic advance,
    input wire logic interleave,
    // address bits
    input wire logic [1:0] load_lsb,
    output logic [1:0] next_lsb
);

    logic [1:0] base_reg; // loaded starting bits
    logic [1:0] count_reg; // accesses since the load
    logic [1:0] count_next;
    logic [1:0] lin_lsb;
    logic [1:0] ilv_lsb;

    // two bits wrap by themselves, so the fifth access repeats the start
    assign count_next = count_reg + BURST_STEP;
    assign lin_lsb = base_reg + count_next;
    assign ilv_lsb = base_reg ^ count_next;
    assign next_lsb = load ? load_lsb : (interleave ? ilv_lsb : lin_lsb);

    // base and count only move on an edge that is not held
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            base_reg <= BURST_START;
            count_reg <= BURST_START;
        end else if (!hold) begin
            if (load) begin
                base_reg <= load_lsb;
                count_reg <= BURST_START;
            end else if (advance) begin
                count_reg <= count_next;
            end
        end
    end

    a_linear_step: assert property (@(posedge core_clk) disable iff (sys_rst)
        advance && !load && !interleave |-> next_lsb == 2'(base_reg + count_reg + BURST_STEP))
        else $error("linear burst step wrong");
    a_interleave_step: assert property (@(posedge core_clk) disable iff (sys_rst)
        advance && !load && interleave |-> next_lsb == (base_reg ^ 2'(count_reg + BURST_STEP)))
        else $error("interleaved burst step wrong");
    a_hold_freezes: assert property (@(posedge core_clk) disable iff (sys_rst)
        hold |=> $stable(count_reg) && $stable(base_reg))
        else $error("burst counter moved on a held edge");

endmodule
`default_nettype wire

/* sbmsc_ctl_model.sv */
// controller model: drives the synchronous command bus and answers core reads
// assumes the bench calls cmd once per cycle; all changes land just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module sbmsc_ctl_model
    import sbmsc_pkg::*;
(
    // clock
    input wire logic core_clk,
    // command bus
    output logic clk_edge_gate,
    output logic chip_en1_n,
    output logic chip_en2,
    output logic chip_en3_n,
    output logic write_n,
    output logic [3:0] byte_wr_n,
    output logic advance_load_select,
    output logic [17:0] addr,
    output logic [31:0] dq_in,
    // memory core answer
    input wire logic [17:0] core_addr,
    output logic [31:0] core_rd_data,
    output logic [3:0] core_rd_par
);
    // read answer follows the address, so a wrong address shows in the data
    assign core_rd_data = {14'h1A5, core_addr};
    assign core_rd_par = core_addr[3:0];

    // bus idles deselected from time zero
    initial begin
        {clk_edge_gate, write_n, advance_load_select, chip_en2} = 4'h4;
        {chip_en1_n, chip_en3_n} = 2'h3;
        byte_wr_n = 4'hF;
        addr = 18'h0;
        dq_in = 32'h0;
    end

    // one bus cycle, held until the next rising edge
    task automatic cmd(input logic gate, input logic sel, input logic wr_n, input logic cont,
                       input logic [17:0] a, input logic [3:0] bw, input logic dv, input logic [31:0] d);
        @(posedge core_clk);
        clk_edge_gate <= gate;
        chip_en1_n <= ~sel;
        chip_en2 <= sel;
        chip_en3_n <= ~sel;
        write_n <= wr_n;
        advance_load_select <= cont;
        addr <= a;
        byte_wr_n <= bw;
        // data only in the asked cycle; else inverted so stale data never passes
        dq_in <= dv ? d : ~dq_in;
    endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the burst, mode pin and sleep block
// assumes sbmsc_ctl_model drives the command bus
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sbmsc_pkg::*;
    // clock, reset and static pins; one flag drives every pin-open input
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic burst_order_select = 1'b0, flow_through_select = 1'b1, deselect_cycle_select = 1'b1;
    logic drive_select = 1'b1, parity_byte_enable = 1'b0, sleep_request = 1'b0, pin_open = 1'b0;
    wire clk_edge_gate, chip_en1_n, chip_en2, chip_en3_n, write_n, advance_load_select;
    wire dq_oe, parity_data_lines_oe, core_rd_en, core_wr_en;
    wire pipelined_mode, single_deselect, high_drive, sleep_active, recovering;
    wire [3:0] byte_wr_n, parity_data_lines_out, core_rd_par, core_byte_en, core_wr_par;
    wire [17:0] addr, core_addr, core_wr_addr;
    wire [31:0] dq_in, dq_out, core_rd_data, core_wr_data;
    int fails = 0, num_checks = 0;

    always #12.5 core_clk = ~core_clk;

    sbmsc_ctrl uut (.core_clk, .sys_rst, .clk_edge_gate, .chip_en1_n, .chip_en2, .chip_en3_n, .write_n,
        .byte_wr_n, .advance_load_select, .addr, .dq_in, .dq_out, .dq_oe, .parity_data_lines_in(dq_in[3:0]),
        .parity_data_lines_out, .parity_data_lines_oe, .burst_order_select, .flow_through_select,
        .flow_through_select_open(pin_open), .deselect_cycle_select, .deselect_cycle_select_open(pin_open),
        .drive_select, .drive_select_open(pin_open), .parity_byte_enable, .parity_byte_enable_open(pin_open),
        .sleep_request, .sleep_request_open(pin_open), .core_addr, .core_rd_en, .core_rd_data, .core_rd_par,
        .core_wr_en, .core_wr_addr, .core_byte_en, .core_wr_data, .core_wr_par, .pipelined_mode,
        .single_deselect, .high_drive, .sleep_active, .recovering);
    sbmsc_ctl_model m (.core_clk, .clk_edge_gate, .chip_en1_n, .chip_en2, .chip_en3_n, .write_n, .byte_wr_n,
        .advance_load_select, .addr, .dq_in, .core_addr, .core_rd_data, .core_rd_par);

    // compare with case equality so unknowns fail
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // deselect cycles
    task automatic idle(input int n);
        repeat (n) m.cmd(1'b0, 1'b0, 1'b1, 1'b0, 18'h0, 4'hF, 1'b0, 32'h0);
    endtask

    // open pins take pull values, then real values show
    task automatic t_open();
        @(posedge core_clk);
        {flow_through_select, deselect_cycle_select, drive_select} <= 3'h0;
        {sleep_request, pin_open} <= 2'h3;
        idle(4);
        #1;
        check("open_pipe", pipelined_mode, 1'b1);
        check("open_desel", single_deselect, 1'b1);
        check("open_drive", high_drive, 1'b0);
        check("open_sleep", sleep_active, 1'b0);
        idle(1);
        {sleep_request, pin_open} <= 2'h0;
        idle(4);
        #1;
        check("drive_high", high_drive, 1'b1);
        $display("test open done");
    endtask

    // load then continue with junk address, sel off and, in linear order, two held edges
    task automatic t_burst(input logic ord, input logic [17:0] a);
        logic g;
        int n;
        n = 0;
        @(posedge core_clk);
        burst_order_select <= ord;
        idle(4);
        m.cmd(1'b0, 1'b1, 1'b1, 1'b0, a, 4'hF, 1'b0, 32'h0);
        for (int i = 0; i < 8; i++) begin
            // the interleaved run stays unheld so four continues in a row show the wrap
            g = !ord && ((i == 2) || (i == 3));
            m.cmd(g, 1'b0, 1'b1, 1'b1, ~a, 4'hF, 1'b0, 32'h0);
            #1;
            check("burst_addr", core_addr, {a[17:2], ord ? a[1:0] ^ n[1:0] : a[1:0] + n[1:0]});
            n += g ? 0 : 1;
        end
        $display("test burst done");
    endtask

    // single read: output latency, deselect length, parity lines
    task automatic t_read(input logic piped, input logic one_desel, input logic par_dis);
        logic on;
        int lat;
        lat = piped ? 3 : 2;
        @(posedge core_clk);
        {flow_through_select, deselect_cycle_select, parity_byte_enable} <= {piped, one_desel, par_dis};
        idle(4);
        #1;
        check("pipe_mode", pipelined_mode, piped);
        check("single_desel", single_deselect, one_desel);
        m.cmd(1'b0, 1'b1, 1'b1, 1'b0, 18'h2C3, 4'h0, 1'b0, 32'h0);
        for (int k = 1; k < 6; k++) begin
            idle(1);
            #1;
            on = (k == lat) || (!one_desel && k == lat + 1);
            check("dq_oe", dq_oe, on);
            check("parity_oe", parity_data_lines_oe, on && !par_dis);
            if (k == lat) check("dq_out", dq_out, {14'h1A5, 18'h2C3});
            if (k == lat) check("par_out", parity_data_lines_out, 4'h3);
        end
        $display("test read done");
    endtask

    // write with late data; all bytes off is an abort
    task automatic t_write(input logic piped, input logic [3:0] bw);
        logic [31:0] got;
        int hits;
        hits = 0;
        got = 32'h0;
        @(posedge core_clk);
        // parity lines off when pipelined, on in flow-through; parity in follows dq_in[3:0]
        {flow_through_select, parity_byte_enable} <= {piped, piped};
        idle(4);
        m.cmd(1'b0, 1'b1, 1'b0, 1'b0, 18'h2A5F0, bw, 1'b0, 32'h0);
        for (int k = 1; k < 7; k++) begin
            m.cmd(1'b0, 1'b0, 1'b1, 1'b0, 18'h0, 4'hF, k == (piped ? 2 : 1), 32'hC35A96E1);
            #1;
            if (core_wr_en === 1'b1) begin
                hits++;
                got = core_wr_data;
                check("wr_addr", core_wr_addr, 18'h2A5F0);
                check("wr_bytes", core_byte_en, 4'(~bw));
                check("wr_par", core_wr_par, piped ? 4'h0 : 4'h1);
            end
        end
        check("wr_count", hits, (bw != 4'hF));
        if (bw != 4'hF) check("wr_data", got, 32'hC35A96E1);
        $display("test write done");
    endtask

    // sleep entry timing, inputs ignored, recovery then normal reads
    task automatic t_sleep();
        logic rec;
        rec = 1'b0;
        idle(1); // nothing pending when sleep is raised
        sleep_request <= 1'b1;
        idle(1);
        #1;
        check("sleep_early", sleep_active, 1'b0);
        idle(2);
        #1;
        check("sleep_on", sleep_active, 1'b1);
        repeat (3) begin
            m.cmd(1'b0, 1'b1, 1'b1, 1'b0, 18'h155, 4'hF, 1'b0, 32'h0);
            #1;
            check("sleep_rd_en", core_rd_en, 1'b0);
            check("sleep_dq_oe", dq_oe, 1'b0);
        end
        idle(1);
        sleep_request <= 1'b0;
        repeat (12) begin
            idle(1); // only deselects while recovering
            #1;
            rec |= recovering;
        end
        check("recovered", {rec, sleep_active, recovering}, 3'h4);
        m.cmd(1'b0, 1'b1, 1'b1, 1'b0, 18'h155, 4'hF, 1'b0, 32'h0);
        idle(1);
        #1;
        check("wake_rd_en", core_rd_en, 1'b1);
        $display("test sleep done");
    endtask

    // print counts and verdict, then stop
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_open();
        t_burst(1'b0, 18'h2B4D1);
        t_burst(1'b1, 18'h1C6A2);
        t_read(1'b1, 1'b1, 1'b0);
        t_read(1'b0, 1'b0, 1'b1);
        t_write(1'b1, 4'h5);
        t_write(1'b0, 4'h5);
        t_write(1'b0, 4'hF);
        t_sleep();
        finish_test();
    end

    // watchdog well beyond the 120 or so cycles the tests need
    initial begin
        #50000;
        fails++;
        finish_test();
    end
endmodule
`default_nettype wire
